// file: include/dcad_consts.vh
// Constants shared by the drive communication address decoder
`ifndef DCAD_CONSTS_VH
`define DCAD_CONSTS_VH

// Command codes on the access port
`define DCAD_FC_READ 8'h03
`define DCAD_FC_WRITE 8'h06

// Error codes returned with an access answer, zero when it succeeds
`define DCAD_ERR_NONE 8'h00
`define DCAD_ERR_CODE 8'h01
`define DCAD_ERR_ADDR 8'h02
`define DCAD_ERR_DATA 8'h03
`define DCAD_ERR_BUSY 8'h04

// Fixed word addresses
`define DCAD_ADDR_CMD 16'h2000
`define DCAD_ADDR_RUN 16'h3000
`define DCAD_ADDR_FAULT 16'h8000

// Upper nibble of the address upper byte that classifies an access
`define DCAD_HI_F_VOL 4'h0
`define DCAD_HI_F_NV 4'hf
`define DCAD_HI_A_VOL 4'h4
`define DCAD_HI_A_NV 4'ha
`define DCAD_HI_MON 4'h7

// Field positions inside the address word
`define DCAD_HI_MSB 15
`define DCAD_HI_LSB 12
`define DCAD_GRP_MSB 11
`define DCAD_GRP_LSB 8
`define DCAD_IDX_MSB 7
`define DCAD_IDX_LSB 0

// Running status words
`define DCAD_RUN_FWD 16'h0001
`define DCAD_RUN_REV 16'h0002
`define DCAD_RUN_STOP 16'h0003

// Control command word range
`define DCAD_CMD_MIN 16'h0001
`define DCAD_CMD_MAX 16'h0007

// Command source selection parameter and its communication value
`define DCAD_CMD_SRC_GRP 4'h0
`define DCAD_CMD_SRC_IDX 8'h02
`define DCAD_CMD_SRC_COMM 16'h0002
`define DCAD_CMD_SRC_RST 16'h0000

`endif

// file: logic/dcad_param_mem.v
// Parameter word store for the F and A groups
module dcad_param_mem #(
  parameter AW = 13,
  parameter DW = 16
) (
  // Clock
  input wire clk,
  // Write side
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read side
  input wire [AW-1:0] rd_addr,
  output wire [DW-1:0] rd_data
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  // Word write, one per cycle
  always @(posedge clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Read is combinational; the caller registers the answer
  assign rd_data = mem_reg[rd_addr];

endmodule // dcad_param_mem

// file: logic/dcad_decoder.v
// Communication address decoder and register bank of the drive
`include "dcad_consts.vh"

module dcad_decoder #(
  parameter IDX_W = 8,
  parameter DW = 16
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Access request from the protocol layer
  input wire REQ_VALID,
  output wire REQ_READY,
  input wire [7:0] REQ_CODE,
  input wire [15:0] REQ_ADDR,
  input wire [DW-1:0] REQ_WDATA,
  // Access answer
  output reg RSP_VALID,
  output reg RSP_ERR,
  output reg [7:0] RSP_ERR_CODE,
  output reg [DW-1:0] RSP_RDATA,
  // Monitoring value lookup
  output reg MON_RD_STB,
  output reg [15:0] MON_ADDR,
  input wire [DW-1:0] MON_DATA,
  // Drive state
  input wire [15:0] FAULT_CODE,
  input wire RUNNING,
  input wire REVERSE,
  // Control command to the drive core
  output reg CMD_STB,
  output reg [2:0] CMD_CODE,
  output reg [DW-1:0] CMD_SRC,
  // Nonvolatile commit request
  output reg NV_WR_STB,
  output reg [15:0] NV_WR_ADDR,
  output reg [DW-1:0] NV_WR_DATA
);

  localparam AW = 5 + IDX_W;
  localparam ST_IDLE = 1'b0;
  localparam ST_MON = 1'b1;

  reg state_reg;
  reg state_next;
  reg [DW-1:0] cmd_src_reg;
  reg [DW-1:0] cmd_src_next;

  // Decode results for the request in this cycle
  wire [3:0] hi_nib;
  wire [3:0] grp;
  wire [IDX_W-1:0] idx;
  wire is_rd;
  wire is_wr;
  wire take;
  reg dec_err;
  reg [7:0] dec_code;
  reg [DW-1:0] dec_rdata;
  reg dec_mon;
  reg mem_we;
  reg mem_is_a;
  reg nv_commit;
  reg cmd_fire;
  wire [AW-1:0] mem_rd_addr;
  wire [AW-1:0] mem_wr_addr;
  wire [DW-1:0] mem_rdata;
  wire [DW-1:0] run_word;

  assign hi_nib = REQ_ADDR[`DCAD_HI_MSB:`DCAD_HI_LSB];
  assign grp = REQ_ADDR[`DCAD_GRP_MSB:`DCAD_GRP_LSB];
  assign idx = REQ_ADDR[`DCAD_IDX_MSB:`DCAD_IDX_LSB];
  assign is_rd = (REQ_CODE == `DCAD_FC_READ);
  assign is_wr = (REQ_CODE == `DCAD_FC_WRITE);
  assign REQ_READY = (state_reg == ST_IDLE);
  assign take = REQ_VALID && REQ_READY;
  assign mem_wr_addr = {mem_is_a, grp, idx};
  // Read half is picked from the address alone, so the decode has no loop through the store
  assign mem_rd_addr = {hi_nib == `DCAD_HI_A_NV, grp, idx};

  // Running status word from the drive state
  assign run_word = !RUNNING ? `DCAD_RUN_STOP :
                    (REVERSE ? `DCAD_RUN_REV : `DCAD_RUN_FWD);

  // Parameter words of the F and A groups
  dcad_param_mem #(
    .AW(AW),
    .DW(DW)
  ) u_mem (
    .clk(CLK),
    .wr_en(mem_we),
    .wr_addr(mem_wr_addr),
    .wr_data(REQ_WDATA),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rdata)
  );

  // Address and command decode
  always @*
  begin
    dec_err = 1'b0;
    dec_code = `DCAD_ERR_NONE;
    dec_rdata = {DW{1'b0}};
    dec_mon = 1'b0;
    mem_we = 1'b0;
    mem_is_a = 1'b0;
    nv_commit = 1'b0;
    cmd_fire = 1'b0;
    if (!is_rd && !is_wr)
    begin
      dec_err = 1'b1;
      dec_code = `DCAD_ERR_CODE;
    end
    else if (is_rd)
    begin
      if (hi_nib == `DCAD_HI_F_NV)
      begin
        // Store half 0 holds the F groups
        dec_rdata = mem_rdata;
      end
      else if (hi_nib == `DCAD_HI_A_NV)
      begin
        // Store half 1 holds the A groups
        dec_rdata = mem_rdata;
      end
      else if (hi_nib == `DCAD_HI_MON)
      begin
        dec_mon = 1'b1;
      end
      else if (REQ_ADDR == `DCAD_ADDR_FAULT)
      begin
        dec_rdata = FAULT_CODE;
      end
      else if (REQ_ADDR == `DCAD_ADDR_RUN)
      begin
        dec_rdata = run_word;
      end
      else
      begin
        // Write-only and unmapped words refuse reads
        dec_err = 1'b1;
        dec_code = `DCAD_ERR_ADDR;
      end
    end
    else
    begin
      if (hi_nib == `DCAD_HI_F_VOL || hi_nib == `DCAD_HI_F_NV)
      begin
        mem_we = 1'b1;
        mem_is_a = 1'b0;
        nv_commit = (hi_nib == `DCAD_HI_F_NV);
        dec_rdata = REQ_WDATA;
      end
      else if (hi_nib == `DCAD_HI_A_VOL || hi_nib == `DCAD_HI_A_NV)
      begin
        mem_we = 1'b1;
        mem_is_a = 1'b1;
        nv_commit = (hi_nib == `DCAD_HI_A_NV);
        dec_rdata = REQ_WDATA;
      end
      else if (REQ_ADDR == `DCAD_ADDR_CMD)
      begin
        dec_rdata = REQ_WDATA;
        if (cmd_src_reg != `DCAD_CMD_SRC_COMM)
        begin
          dec_err = 1'b1;
          dec_code = `DCAD_ERR_BUSY;
        end
        else if (REQ_WDATA < `DCAD_CMD_MIN || REQ_WDATA > `DCAD_CMD_MAX)
        begin
          dec_err = 1'b1;
          dec_code = `DCAD_ERR_DATA;
        end
        else
        begin
          cmd_fire = 1'b1;
        end
      end
      else
      begin
        // Status and unmapped words refuse writes, nothing stored
        dec_err = 1'b1;
        dec_code = `DCAD_ERR_ADDR;
      end
    end
    if (!take)
    begin
      mem_we = 1'b0;
      nv_commit = 1'b0;
      cmd_fire = 1'b0;
    end
  end

  // Shadow of the command source selection, tracks writes to its word
  always @*
  begin
    cmd_src_next = cmd_src_reg;
    if (mem_we && !mem_is_a && grp == `DCAD_CMD_SRC_GRP && idx == `DCAD_CMD_SRC_IDX)
    begin
      cmd_src_next = REQ_WDATA;
    end
  end

  // Sequencer: monitoring reads wait one cycle for the lookup
  always @*
  begin
    case (state_reg)
      ST_IDLE:
      begin
        state_next = (take && dec_mon) ? ST_MON : ST_IDLE;
      end
      ST_MON:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State, shadow and output registers
  always @(posedge CLK)
  begin
    if (RST)
    begin
      state_reg <= ST_IDLE;
      cmd_src_reg <= `DCAD_CMD_SRC_RST;
      RSP_VALID <= 1'b0;
      RSP_ERR <= 1'b0;
      RSP_ERR_CODE <= `DCAD_ERR_NONE;
      RSP_RDATA <= {DW{1'b0}};
      MON_RD_STB <= 1'b0;
      MON_ADDR <= 16'h0000;
      CMD_STB <= 1'b0;
      CMD_CODE <= 3'h0;
      CMD_SRC <= `DCAD_CMD_SRC_RST;
      NV_WR_STB <= 1'b0;
      NV_WR_ADDR <= 16'h0000;
      NV_WR_DATA <= {DW{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      cmd_src_reg <= cmd_src_next;
      CMD_SRC <= cmd_src_next;
      RSP_VALID <= 1'b0;
      MON_RD_STB <= 1'b0;
      CMD_STB <= 1'b0;
      NV_WR_STB <= 1'b0;
      if (state_reg == ST_MON)
      begin
        // Lookup answer is taken one cycle after the strobe
        RSP_VALID <= 1'b1;
        RSP_ERR <= 1'b0;
        RSP_ERR_CODE <= `DCAD_ERR_NONE;
        RSP_RDATA <= MON_DATA;
      end
      else if (take && dec_mon)
      begin
        MON_RD_STB <= 1'b1;
        MON_ADDR <= REQ_ADDR;
      end
      else if (take)
      begin
        RSP_VALID <= 1'b1;
        RSP_ERR <= dec_err;
        RSP_ERR_CODE <= dec_code;
        RSP_RDATA <= dec_rdata;
      end
      if (cmd_fire)
      begin
        CMD_STB <= 1'b1;
        CMD_CODE <= REQ_WDATA[2:0];
      end
      if (nv_commit)
      begin
        // Persist under the canonical read address of the word
        NV_WR_STB <= 1'b1;
        NV_WR_ADDR <= {mem_is_a ? `DCAD_HI_A_NV : `DCAD_HI_F_NV, grp, idx};
        NV_WR_DATA <= REQ_WDATA;
      end
    end
  end

endmodule // dcad_decoder

// file: tb/dcad_core_model.sv
// Drive core model facing the decoder: run state and monitoring values
module dcad_core_model (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Accepted commands
  input wire CMD_STB,
  input wire [2:0] CMD_CODE,
  // Monitoring lookup
  input wire MON_RD_STB,
  input wire [15:0] MON_ADDR,
  output logic [15:0] MON_DATA,
  // Run state
  output logic RUNNING,
  output logic REVERSE
);
  timeunit 1ns;
  timeprecision 1ns;
  // Value only while strobed, its inverse otherwise so a late sample shows
  always_comb MON_DATA = MON_RD_STB ? MON_ADDR ^ 16'hc3a5 : ~(MON_ADDR ^ 16'hc3a5);
  // Odd codes up to 4 run forward, even reverse, 5 and 6 stop, 7 holds
  always_ff @(posedge CLK)
    if (RST) {RUNNING, REVERSE} <= 2'b00;
    else if (CMD_STB && CMD_CODE < 3'h5) {RUNNING, REVERSE} <= {1'b1, !CMD_CODE[0]};
    else if (CMD_STB && CMD_CODE != 3'h7) {RUNNING, REVERSE} <= 2'b00;
endmodule // dcad_core_model

// file: tb/dcad_chk_sva.sv
// Port checker of the address decoder
module dcad_chk (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Request and answer
  input wire REQ_VALID,
  input wire REQ_READY,
  input wire [7:0] REQ_CODE,
  input wire [15:0] REQ_ADDR,
  input wire RSP_VALID,
  input wire RSP_ERR,
  input wire [7:0] RSP_ERR_CODE,
  input wire [15:0] RSP_RDATA,
  // Drive side
  input wire MON_RD_STB,
  input wire [15:0] MON_ADDR,
  input wire [15:0] FAULT_CODE,
  input wire RUNNING,
  input wire REVERSE,
  input wire CMD_STB,
  input wire [2:0] CMD_CODE,
  input wire [15:0] CMD_SRC,
  input wire NV_WR_STB,
  input wire [15:0] NV_WR_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Taken reads and writes
  wire tk = REQ_VALID && REQ_READY;
  wire rd = tk && REQ_CODE == 8'h03;
  wire wr = tk && REQ_CODE == 8'h06;
  wire [3:0] hi = REQ_ADDR[15:12];
  AST_MON: assert property (rd && hi == 4'h7 |=> MON_RD_STB && !REQ_READY &&
    MON_ADDR == $past(REQ_ADDR) ##1 RSP_VALID) else $error("monitor read");
  AST_CODE: assert property (tk && REQ_CODE != 8'h03 && REQ_CODE != 8'h06 |=> RSP_VALID &&
    RSP_ERR && RSP_ERR_CODE == 8'h01) else $error("bad code answer");
  AST_RUN: assert property (rd && REQ_ADDR == 16'h3000 |=> RSP_RDATA ==
    (!$past(RUNNING) ? 16'h0003 : $past(REVERSE) ? 16'h0002 : 16'h0001)) else $error("run word");
  AST_FLT: assert property (rd && REQ_ADDR == 16'h8000 |=>
    RSP_RDATA == $past(FAULT_CODE)) else $error("fault word");
  AST_WO: assert property (rd && REQ_ADDR == 16'h2000 |=>
    RSP_ERR && RSP_ERR_CODE == 8'h02) else $error("command read");
  AST_RO: assert property (wr && (REQ_ADDR == 16'h3000 || REQ_ADDR == 16'h8000) |=>
    RSP_ERR_CODE == 8'h02 && !NV_WR_STB && !CMD_STB) else $error("status write");
  AST_NV: assert property (wr && (hi == 4'hf || hi == 4'ha) |=> NV_WR_STB && !RSP_ERR &&
    NV_WR_ADDR == $past(REQ_ADDR)) else $error("commit missing");
  AST_VOL: assert property (wr && (hi == 4'h0 || hi == 4'h4) |=> RSP_VALID &&
    !RSP_ERR && !NV_WR_STB) else $error("volatile write");
  AST_SRC: assert property (CMD_STB |-> CMD_SRC == 16'h0002 && CMD_CODE != 3'h0 &&
    $past(wr && REQ_ADDR == 16'h2000)) else $error("command accepted");
  // Main scenarios reached
  cover property (MON_RD_STB);
  cover property (CMD_STB);
  cover property (NV_WR_STB);
endmodule // dcad_chk

bind dcad_decoder dcad_chk u_dcad_chk (.CLK, .RST, .REQ_VALID, .REQ_READY, .REQ_CODE,
  .REQ_ADDR, .RSP_VALID, .RSP_ERR, .RSP_ERR_CODE, .RSP_RDATA, .MON_RD_STB, .MON_ADDR,
  .FAULT_CODE, .RUNNING, .REVERSE, .CMD_STB, .CMD_CODE, .CMD_SRC, .NV_WR_STB, .NV_WR_ADDR);

// file: tb/tb.sv
// Self-checking bench of the address decoder
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 0, RST = 1, REQ_VALID = 0;
  logic [7:0] REQ_CODE = 0, ec;
  logic [15:0] REQ_ADDR = 0, REQ_WDATA = 0, FAULT_CODE = 0, rd, a, d, st;
  wire REQ_READY, RSP_VALID, RSP_ERR, MON_RD_STB, CMD_STB, NV_WR_STB, RUNNING, REVERSE;
  wire [7:0] RSP_ERR_CODE;
  wire [15:0] RSP_RDATA, MON_ADDR, MON_DATA, CMD_SRC, NV_WR_ADDR, NV_WR_DATA;
  wire [2:0] CMD_CODE;
  int err_total = 0, cmp_count = 0, cyc = 0;
  dcad_decoder u_dcad_decoder (.CLK, .RST, .REQ_VALID, .REQ_READY, .REQ_CODE, .REQ_ADDR,
    .REQ_WDATA, .RSP_VALID, .RSP_ERR, .RSP_ERR_CODE, .RSP_RDATA, .MON_RD_STB, .MON_ADDR,
    .MON_DATA, .FAULT_CODE, .RUNNING, .REVERSE, .CMD_STB, .CMD_CODE, .CMD_SRC, .NV_WR_STB,
    .NV_WR_ADDR, .NV_WR_DATA);
  dcad_core_model u_dcad_core_model (.CLK, .RST, .CMD_STB, .CMD_CODE, .MON_RD_STB,
    .MON_ADDR, .MON_DATA, .RUNNING, .REVERSE);
  // Clock and hang limit
  always #2 CLK = ~CLK;
  always @(posedge CLK)
    if (++cyc == 5000)
    begin
      err_total++;
      stop_test();
    end
  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Compare seen against expected
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One word access; held until taken, answer captured when valid
  task automatic acc(input logic [7:0] c, input logic [15:0] ad, input logic [15:0] dt);
    REQ_CODE <= c;
    REQ_ADDR <= ad;
    REQ_WDATA <= dt;
    REQ_VALID <= 1'b1;
    #1;
    repeat (4) if (REQ_READY !== 1'b1) @(posedge CLK) #1;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    #1;
    repeat (4) if (RSP_VALID !== 1'b1) @(posedge CLK) #1;
    rd = RSP_RDATA;
    ec = RSP_ERR_CODE;
    @(posedge CLK);
  endtask
  // Access expected to answer with a given error code
  task automatic acc_err(input logic [7:0] c, input logic [15:0] ad, dt, input logic [7:0] e);
    acc(c, ad, dt);
    chk({8'h00, ec}, {8'h00, e});
  endtask
  // Run word expected after a command
  function automatic logic [15:0] exp_run(input logic [2:0] c, input logic [15:0] p);
    return c < 3'h5 ? (c[0] ? 16'h0001 : 16'h0002) : (c == 3'h7 ? p : 16'h0003);
  endfunction
  // Main sequence
  initial
  begin
    void'($urandom(36));
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    // Volatile and persistent writes to F and A groups, read back
    for (int i = 0; i < 16; i++)
    begin
      a = {i[0] ? 4'ha : 4'hf, i[3:0], 8'($urandom_range(16, 255))};
      d = 16'($urandom);
      acc(8'h06, i[1] ? a : a ^ {i[0] ? 4'he : 4'hf, 12'h000}, d);
      chk(rd, d);
      if (i[1]) chk(NV_WR_DATA, d);
      if (i[1]) chk(NV_WR_ADDR, a);
      acc(8'h03, a, 16'h0000);
      chk(rd, d);
    end
    // Monitoring lookups
    for (int i = 0; i < 4; i++)
    begin
      a = {4'h7, 12'($urandom)};
      acc(8'h03, a, 16'h0000);
      chk(rd, a ^ 16'hc3a5);
    end
    d = 16'($urandom);
    FAULT_CODE <= d;
    acc(8'h03, 16'h8000, 16'h0000);
    chk(rd, d);
    // Refused accesses
    acc_err(8'h03, 16'h2000, 16'h0000, 8'h02);
    acc_err(8'h06, 16'h3000, 16'h0001, 8'h02);
    acc_err(8'h06, 16'h8000, 16'h0001, 8'h02);
    acc_err(8'h03, 16'h1234, 16'h0000, 8'h02);
    acc_err(8'h10, 16'hf010, 16'h0000, 8'h01);
    acc_err(8'h06, 16'h2000, 16'h0001, 8'h04);
    st = 16'h0003;
    acc(8'h03, 16'h3000, 16'h0000);
    chk(rd, st);
    // Hand control to the link, then every command and random ones
    acc(8'h06, 16'h0002, 16'h0002);
    acc_err(8'h06, 16'h2000, 16'h0008, 8'h03);
    acc_err(8'h06, 16'h2000, 16'h0000, 8'h03);
    for (int i = 0; i < 14; i++)
    begin
      d = i < 7 ? 16'(i + 1) : 16'($urandom_range(1, 7));
      acc_err(8'h06, 16'h2000, d, 8'h00);
      chk({13'h0000, CMD_CODE}, d);
      st = exp_run(d[2:0], st);
      acc(8'h03, 16'h3000, 16'h0000);
      chk(rd, st);
    end
    stop_test();
  end
endmodule // tb
